// ### include/tmw_pkg.sv
package tmw_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_COUNT  = 5'h04;
  localparam logic [4:0] OFS_CMPA   = 5'h08;
  localparam logic [4:0] OFS_CMPB   = 5'h0C;
  localparam logic [4:0] OFS_FLAGS  = 5'h10;
  localparam logic [4:0] OFS_PRESC  = 5'h14;
  localparam logic [4:0] OFS_FORCE  = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;

  // Control register fields
  localparam int CTRL_ACT_A_LSB = 0;
  localparam int CTRL_ACT_B_LSB = 2;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_RUN_BIT   = 7;

  // Flag register fields
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_CMPA_BIT = 1;
  localparam int FLAG_CMPB_BIT = 2;

  // Force register fields
  localparam int FORCE_A_BIT = 0;
  localparam int FORCE_B_BIT = 1;

  // Waveform mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CTC    = 3'h2;
  localparam logic [2:0] MODE_FPWM   = 3'h3;
  localparam logic [2:0] MODE_FPWM_A = 3'h7;

  // Output action codes
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Counter extremes, reset value and bus response codes
  localparam logic [7:0] CNT_BOTTOM  = 8'h00;
  localparam logic [7:0] CNT_MAX     = 8'hFF;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hdl/tmw_timer8.sv
`timescale 1ns/1ps
module tmw_timer8
  import tmw_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // General port bits behind the two compare pins
  input  wire logic        port_a_value,
  input  wire logic        port_a_dir,
  input  wire logic        port_b_value,
  input  wire logic        port_b_dir,
  // Compare pins
  output logic             compare_a_output,
  output logic             compare_a_output_oe,
  output logic             compare_b_output,
  output logic             compare_b_output_oe
);

  logic [1:0]  act_a_q, act_b_q;
  logic [2:0]  mode_q;
  logic [7:0]  presc_q, div_q, counter_value_q, top;
  logic [7:0]  cmpa_buf_q, cmpb_buf_q, compare_a_value_q, compare_b_value_q;
  logic        run_q, tick, block_q, state_a_q, state_b_q;
  logic        overflow_flag_q, compare_a_flag_q, compare_b_flag_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q, rd_data;
  logic [3:0]  wstrb_q;
  logic        we, wr_lane0, wr_ok, rd_ok;
  logic        wr_ctrl, wr_count, wr_cmpa, wr_cmpb, wr_flags, wr_presc, wr_force;
  logic        fast_pwm, non_pwm, at_top, match_a, match_b, force_a, force_b, ovf_set;

  // Write channel: address and data are taken in either order
  assign we = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end else if (we) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end else if (we) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_lane0 = we && wstrb_q[0];
  assign wr_ctrl  = wr_lane0 && awaddr_q == OFS_CTRL;
  assign wr_count = wr_lane0 && awaddr_q == OFS_COUNT;
  assign wr_cmpa  = wr_lane0 && awaddr_q == OFS_CMPA;
  assign wr_cmpb  = wr_lane0 && awaddr_q == OFS_CMPB;
  assign wr_flags = wr_lane0 && awaddr_q == OFS_FLAGS;
  assign wr_presc = wr_lane0 && awaddr_q == OFS_PRESC;
  assign wr_force = wr_lane0 && awaddr_q == OFS_FORCE;
  assign wr_ok    = awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (we) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:   rd_data[7:0] = {run_q, mode_q, act_b_q, act_a_q};
      OFS_COUNT:  rd_data[7:0] = counter_value_q;
      OFS_CMPA:   rd_data[7:0] = cmpa_buf_q;
      OFS_CMPB:   rd_data[7:0] = cmpb_buf_q;
      OFS_FLAGS:  rd_data[2:0] = {compare_b_flag_q, compare_a_flag_q, overflow_flag_q};
      OFS_PRESC:  rd_data[7:0] = presc_q;
      OFS_FORCE:  rd_data      = 32'h0000_0000;
      OFS_STATUS: rd_data[1:0] = {state_b_q, state_a_q};
      default:    rd_ok        = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Control and prescaler settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_a_q <= ACT_NONE;
      act_b_q <= ACT_NONE;
      mode_q  <= MODE_NORMAL;
      run_q   <= 1'b0;
      presc_q <= RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        act_a_q <= wdata_q[CTRL_ACT_A_LSB +: 2];
        act_b_q <= wdata_q[CTRL_ACT_B_LSB +: 2];
        mode_q  <= wdata_q[CTRL_MODE_LSB +: 3];
        run_q   <= wdata_q[CTRL_RUN_BIT];
      end
      if (wr_presc) presc_q <= wdata_q[7:0];
    end
  end

  // Tick every presc_q+1 clocks while running
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_q || tick) begin
      div_q <= RST_BYTE;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tick     = run_q && div_q == presc_q;
  assign fast_pwm = mode_q == MODE_FPWM || mode_q == MODE_FPWM_A;
  assign non_pwm  = mode_q == MODE_NORMAL || mode_q == MODE_CTC;
  assign top      = mode_q == MODE_FPWM_A ? compare_a_value_q : CNT_MAX;
  assign at_top   = fast_pwm && counter_value_q == top;
  assign match_a  = tick && !block_q && counter_value_q == compare_a_value_q;
  assign match_b  = tick && !block_q && counter_value_q == compare_b_value_q;
  assign force_a  = wr_force && wdata_q[FORCE_A_BIT] && non_pwm;
  assign force_b  = wr_force && wdata_q[FORCE_B_BIT] && non_pwm;

  // Counter: software write overrides counting; sequence from mode and compare A
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value_q <= CNT_BOTTOM;
    end else if (wr_count) begin
      counter_value_q <= wdata_q[7:0];
    end else if (tick) begin
      if (mode_q == MODE_CTC && counter_value_q == compare_a_value_q) begin
        counter_value_q <= CNT_BOTTOM;
      end else if (at_top) begin
        counter_value_q <= CNT_BOTTOM;
      end else begin
        counter_value_q <= counter_value_q + 8'h01;
      end
    end
  end

  // Blocks matches on the first tick after a counter write, even stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Compare values: direct outside PWM, reloaded at restart in fast PWM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_buf_q        <= RST_BYTE;
      cmpb_buf_q        <= RST_BYTE;
      compare_a_value_q <= RST_BYTE;
      compare_b_value_q <= RST_BYTE;
    end else begin
      if (wr_cmpa) cmpa_buf_q <= wdata_q[7:0];
      if (wr_cmpb) cmpb_buf_q <= wdata_q[7:0];
      if (!fast_pwm) begin
        compare_a_value_q <= wr_cmpa ? wdata_q[7:0] : cmpa_buf_q;
        compare_b_value_q <= wr_cmpb ? wdata_q[7:0] : cmpb_buf_q;
      end else if (tick && at_top) begin
        compare_a_value_q <= cmpa_buf_q;
        compare_b_value_q <= cmpb_buf_q;
      end
    end
  end

  // Overflow: at FF in non-PWM, at top in fast PWM; set beats clear
  assign ovf_set = tick && (fast_pwm ? at_top : counter_value_q == CNT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_q  <= 1'b0;
      compare_a_flag_q <= 1'b0;
      compare_b_flag_q <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag_q <= 1'b1;
      end else if (wr_flags && wdata_q[FLAG_OVF_BIT]) begin
        overflow_flag_q <= 1'b0;
      end
      if (match_a) begin
        compare_a_flag_q <= 1'b1;
      end else if (wr_flags && wdata_q[FLAG_CMPA_BIT]) begin
        compare_a_flag_q <= 1'b0;
      end
      if (match_b) begin
        compare_b_flag_q <= 1'b1;
      end else if (wr_flags && wdata_q[FLAG_CMPB_BIT]) begin
        compare_b_flag_q <= 1'b0;
      end
    end
  end

  // Next compare output state; action field read live, never buffered
  function automatic logic next_state(input logic       cur,
                                      input logic [1:0] act,
                                      input logic       hit,
                                      input logic       restart,
                                      input logic       tog_ok);
    logic r;
    r = cur;
    if (non_pwm) begin
      if (hit) begin
        case (act)
          ACT_TOGGLE: r = !cur;
          ACT_CLEAR:  r = 1'b0;
          ACT_SET:    r = 1'b1;
          default:    r = cur;
        endcase
      end
    end else if (fast_pwm) begin
      if (act == ACT_TOGGLE && tog_ok && hit) begin
        r = !cur;
      end
      // Restart applied after match so top wins when compare equals top
      if (act == ACT_CLEAR) begin
        if (hit) r = 1'b0;
        if (restart) r = 1'b1;
      end else if (act == ACT_SET) begin
        if (hit) r = 1'b1;
        if (restart) r = 1'b0;
      end
    end
    return r;
  endfunction

  // Mode changes leave these untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_a_q <= 1'b0;
      state_b_q <= 1'b0;
    end else begin
      state_a_q <= next_state(state_a_q, act_a_q, match_a || force_a,
                              tick && at_top, mode_q[2]);
      state_b_q <= next_state(state_b_q, act_b_q, match_b || force_b,
                              tick && at_top, 1'b0);
    end
  end

  // Pin override; direction stays with the port bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_output    <= 1'b0;
      compare_a_output_oe <= 1'b0;
      compare_b_output    <= 1'b0;
      compare_b_output_oe <= 1'b0;
    end else begin
      compare_a_output    <= act_a_q != ACT_NONE ? state_a_q : port_a_value;
      compare_a_output_oe <= port_a_dir;
      compare_b_output    <= act_b_q != ACT_NONE ? state_b_q : port_b_value;
      compare_b_output_oe <= port_b_dir;
    end
  end

  a_reset_state: assert property (@(posedge aclk) !aresetn |=> !state_a_q && !state_b_q)
    else $error("compare state not cleared by reset");
  a_pin_override: assert property (@(posedge aclk) disable iff (!aresetn)
    act_a_q != ACT_NONE |=> compare_a_output == $past(state_a_q))
    else $error("pin A not showing compare state");
  a_normal_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && mode_q == MODE_NORMAL && !wr_count |=> counter_value_q == $past(counter_value_q) + 8'h01)
    else $error("normal mode did not increment");
  a_overflow_ff: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && non_pwm && counter_value_q == CNT_MAX && !wr_count
    |=> overflow_flag_q && counter_value_q == CNT_BOTTOM)
    else $error("overflow flag missing at wrap");
  a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && mode_q == MODE_CTC && counter_value_q == compare_a_value_q && !wr_count
    |=> counter_value_q == CNT_BOTTOM)
    else $error("clear-on-match did not clear counter");
  a_match_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    match_a |=> compare_a_flag_q)
    else $error("compare A flag not set on match");
  a_block_match: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && block_q && !wr_flags |=> $stable({compare_a_flag_q, compare_b_flag_q}))
    else $error("match not blocked after counter write");
  a_force_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    force_a && act_a_q == ACT_TOGGLE |=> state_a_q != $past(state_a_q))
    else $error("force strobe did not toggle A");
  a_pwm_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && at_top && act_a_q == ACT_CLEAR |=> state_a_q ##1 compare_a_output || !act_a_q[1])
    else $error("non-inverting PWM not set at restart");

endmodule

// ### dv/timer8_waveform_modes_tb.sv
`timescale 1ns/1ps
module timer8_waveform_modes_tb;
  import tmw_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pav, pad, pbv, pbd, oa, oae, ob, obe;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, lfsr_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, sa;
  int          fail_count, n_tests, i, per, hi, eper, ehi;
  int          cfg [6][3] = '{'{3, 2, 8'h40}, '{3, 3, 8'h40}, '{7, 1, 8'h1F},
                              '{3, 1, 8'h40}, '{3, 2, 8'h00}, '{3, 2, 8'hFF}};
  int          codes [6] = '{1, 2, 3, 1, 3, 0};

  tmw_timer8 DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_value(pav), .port_a_dir(pad), .port_b_value(pbv), .port_b_dir(pbd),
    .compare_a_output(oa), .compare_a_output_oe(oae),
    .compare_b_output(ob), .compare_b_output_oe(obe)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    do @(posedge aclk); while (!bvalid);
    check(bresp, RESP_OKAY);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rr);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Period and high time from first rise, fall and next rise of the A pin; zero when it never cycles
  task automatic measure(output int p, output int h);
    int   t1, tf, t2, k;
    logic pv;
    t1 = -1;
    tf = -1;
    t2 = -1;
    pv = oa;
    for (k = 0; k < 1200; k++) begin
      @(posedge aclk);
      if (oa && !pv && t1 >= 0 && tf >= 0 && t2 < 0) t2 = k;
      if (oa && !pv && t1 < 0) t1 = k;
      if (!oa && pv && t1 >= 0 && tf < 0) tf = k;
      pv = oa;
    end
    p = (t2 < 0) ? 0 : t2 - t1;
    h = (t2 < 0) ? 0 : tf - t1;
  endtask

  // Expected fast PWM waveform on pin A
  task automatic pwm_model(input int m, input int act, input int cmp, output int p, output int h);
    int top;
    top = (m == 7) ? cmp : 255;
    p = 0;
    h = 0;
    if (act == 1) begin
      if (m == 7) begin
        p = 2 * (top + 1);
        h = top + 1;
      end
    end else if (cmp < top) begin
      p = top + 1;
      h = (act == 2) ? cmp + 1 : top - cmp;
    end
  endtask

  initial begin
    #(50 * 60000);
    fail_count++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {pav, pad, pbv, pbd} = '0;
    awaddr = '0;
    araddr = '0;
    wdata  = '0;
    wstrb  = 4'hF;
    lfsr_q = 32'he2952afe;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({oa, ob, oae, obe}, 4'h0);
    for (i = 0; i < 8; i++) begin
      rd(5'(i * 4), d, r);
      check(d, 32'h0);
    end
    rd(5'h02, d, r);
    check(r, RESP_SLVERR);
    sa = 2'h0;
    for (i = 0; i < 6; i++) begin
      wr(OFS_CTRL, 32'(codes[i] | (codes[i] << 2)));
      wr(OFS_FORCE, 32'h3);
      if (codes[i] == 1) sa = ~sa;
      if (codes[i] == 2) sa = 2'h0;
      if (codes[i] == 3) sa = 2'h3;
      rd(OFS_STATUS, d, r);
      check(d, {30'h0, sa});
    end
    for (i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      pav <= lfsr_q[0];
      pad <= lfsr_q[1];
      pbv <= lfsr_q[2];
      pbd <= lfsr_q[3];
      wr(OFS_CTRL, {28'h0, lfsr_q[7:4]});
      repeat (2) @(posedge aclk);
      check(oa, (lfsr_q[5:4] != 0) ? sa[0] : pav);
      check(ob, (lfsr_q[7:6] != 0) ? sa[1] : pbv);
      check({oae, obe}, {pad, pbd});
    end
    wr(OFS_CTRL, 32'(MODE_CTC) << 4);
    rd(OFS_STATUS, d, r);
    check(d, {30'h0, sa});
    // Count written equal to compare: first match must be swallowed
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CMPA, 32'hFF);
    wr(OFS_COUNT, 32'hFF);
    wr(OFS_PRESC, 32'h0F);
    wr(OFS_CTRL, 32'h80);
    repeat (40) @(posedge aclk);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, d, r);
    check(d >= 1 && d <= 5, 1'b1);
    rd(OFS_FLAGS, d, r);
    check(d[FLAG_OVF_BIT], 1'b1);
    check(d[FLAG_CMPA_BIT], 1'b0);
    // Compare below count: no match before wrap
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_COUNT, 32'h10);
    wr(OFS_CMPA, 32'h03);
    wr(OFS_CTRL, 32'h80 | (32'(MODE_CTC) << 4));
    repeat (20) @(posedge aclk);
    wr(OFS_CTRL, 32'(MODE_CTC) << 4);
    rd(OFS_COUNT, d, r);
    check(d > 32'h10, 1'b1);
    rd(OFS_FLAGS, d, r);
    check(d[FLAG_CMPA_BIT], 1'b0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CTRL, 32'h80 | (32'(MODE_CTC) << 4) | 32'(ACT_TOGGLE));
    measure(per, hi);
    check(per, 8);
    check(hi, 4);
    wr(OFS_CTRL, 32'(MODE_CTC) << 4);
    rd(OFS_COUNT, d, r);
    check(d <= 3, 1'b1);
    rd(OFS_FLAGS, d, r);
    check(d[FLAG_CMPA_BIT], 1'b1);
    for (i = 0; i < 6; i++) begin
      wr(OFS_CTRL, 32'(cfg[i][0] << 4));
      wr(OFS_CMPA, 32'(cfg[i][2]));
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CTRL, 32'(32'h80 | (cfg[i][0] << 4) | cfg[i][1]));
      repeat (600) @(posedge aclk);
      measure(per, hi);
      pwm_model(cfg[i][0], cfg[i][1], cfg[i][2], eper, ehi);
      check(per, eper);
      check(hi, ehi);
    end
    print_verdict();
  end
endmodule
